// ### rtl/oie_pkg.sv
// Constants and types shared by the interrupt enable pair.
// Assumes one 50 MHz controller clock and a synchronous active-high reset.
`default_nettype none

package oie_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned EVT_N  = 7;

    // ****************************************************************
    // Register offsets, bytes from the controller base address.
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_ENABLE_SET   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 8'h14;

    // ****************************************************************
    // Field positions and masks.
    // ****************************************************************
    localparam int unsigned BIT_MASTER        = 31;
    localparam int unsigned BIT_OWNERSHIP     = 30;
    localparam int unsigned BIT_ROOT_PORT     = 6;
    localparam int unsigned BIT_FRAME_OVF     = 5;
    localparam int unsigned BIT_FATAL_ERR     = 4;
    localparam int unsigned BIT_RESUME        = 3;
    localparam int unsigned BIT_FRAME_START   = 2;
    localparam int unsigned BIT_DONE_WRITTEN  = 1;
    localparam int unsigned BIT_SCHED_OVERRUN = 0;

    localparam logic [DATA_W-1:0] ENABLE_MASK   = 32'hc000_007f;
    localparam logic [DATA_W-1:0] EVENT_MASK    = 32'h4000_007f;
    localparam logic [DATA_W-1:0] RESERVED_MASK = 32'h3fff_ff80;
    localparam logic [DATA_W-1:0] ENABLE_RESET  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;

    // ****************************************************************
    // Access sequencer states, one-hot.
    // ****************************************************************
    typedef enum logic [1:0] {
        OIE_IDLE = 2'h1,
        OIE_ACK  = 2'h2
    } oie_state_t;

endpackage : oie_pkg

`default_nettype wire

// ### rtl/oie_gate_if.sv
// Carrier between the register block and the request gate.
// Assumes both ends sit on the same controller clock.
`default_nettype none

interface oie_gate_if;
    logic [oie_pkg::DATA_W-1:0] flags;
    logic [oie_pkg::DATA_W-1:0] enables;
    logic [oie_pkg::DATA_W-1:0] pending;
    logic                       request;

    modport gate (input flags, input enables, output pending, output request);
    modport user (output flags, output enables, input pending, input request);
endinterface : oie_gate_if

`default_nettype wire

// ### rtl/oie_gate.sv
// Combinational request gate: events masked by their enables; the request also by the master.
// Assumes flags and enables come from logic on the controller clock.
`default_nettype none

module oie_gate (
    oie_gate_if.gate gif
);

    logic [oie_pkg::DATA_W-1:0] masked;

    // ****************************************************************
    // Per-event gating.
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < oie_pkg::DATA_W; gi++) begin : g_evt
            if (oie_pkg::EVENT_MASK[gi]) begin : g_live
                assign masked[gi] = gif.flags[gi] & gif.enables[gi];
            end else begin : g_dead
                assign masked[gi] = 1'b0;
            end
        end
    endgenerate

    assign gif.pending = masked;
    assign gif.request = gif.enables[oie_pkg::BIT_MASTER] & (|masked);

endmodule : oie_gate

`default_nettype wire

// ### rtl/oie_top.sv
// Interrupt enable pair: set register, clear alias and the request output.
// Assumes the register port and event flags are driven on ref_clk.
`default_nettype none

module oie_top #(
    parameter int unsigned ADDR_W = oie_pkg::ADDR_W,
    parameter int unsigned DATA_W = oie_pkg::DATA_W
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              soft_rst,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic [DATA_W-1:0] event_flags,
    output var  logic [DATA_W-1:0] reg_rdata,
    output var  logic              reg_ack,
    output var  logic              reg_busy,
    output var  logic              reserved_write,
    output var  logic              master_irq_enable,
    output var  logic [DATA_W-1:0] pending_events,
    output var  logic              irq_req
);

    // ****************************************************************
    // State record.
    // ****************************************************************
    typedef struct packed {
        oie_pkg::oie_state_t state;
        logic [DATA_W-1:0]   enable;
        logic [DATA_W-1:0]   rdata;
        logic [DATA_W-1:0]   pending;
        logic                ack;
        logic                busy;
        logic                rsv_wr;
        logic                irq;
    } oie_regs_t;

    oie_regs_t regs_r;
    oie_regs_t regs_nxt;

    oie_gate_if gif ();

    logic [DATA_W-1:0] enable_next;

    // ****************************************************************
    // Address decode.
    // ****************************************************************
    function automatic logic oie_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction : oie_hit

    // ****************************************************************
    // Request gate, fed from the enables as they will stand after this
    // edge so that a clear drops the request on the very next clock.
    // ****************************************************************
    assign gif.flags   = event_flags;
    assign gif.enables = enable_next;

    oie_gate u_gate (
        .gif (gif.gate)
    );

    // ****************************************************************
    // Enable storage update.
    // ****************************************************************
    always_comb begin
        logic take_wr;
        take_wr     = reg_wr && (regs_r.state == oie_pkg::OIE_IDLE);
        enable_next = regs_r.enable;
        if (soft_rst) begin
            enable_next = oie_pkg::ENABLE_RESET;
        end else if (take_wr && oie_hit(reg_addr, oie_pkg::OFS_ENABLE_SET)) begin
            // Zeros leave bits alone, so no read-modify-write is needed.
            enable_next = regs_r.enable | (reg_wdata & oie_pkg::ENABLE_MASK);
        end else if (take_wr && oie_hit(reg_addr, oie_pkg::OFS_ENABLE_CLEAR)) begin
            // Covers master, ownership and all seven event enables alike.
            enable_next = regs_r.enable &
                          ~(reg_wdata & oie_pkg::ENABLE_MASK);
        end
    end

    // ****************************************************************
    // Access sequencer and read path.
    // ****************************************************************
    always_comb begin
        logic take_wr;
        logic take_rd;
        take_wr  = reg_wr && (regs_r.state == oie_pkg::OIE_IDLE);
        take_rd  = reg_rd && !reg_wr && (regs_r.state == oie_pkg::OIE_IDLE);
        regs_nxt = regs_r;

        regs_nxt.enable  = enable_next;
        regs_nxt.pending = gif.pending;
        regs_nxt.irq     = gif.request;
        regs_nxt.ack     = 1'b0;

        // Software is expected to keep reserved bits at zero; flag it if not.
        if (take_wr && ((reg_wdata & oie_pkg::RESERVED_MASK) != '0)) begin
            regs_nxt.rsv_wr = 1'b1;
        end

        case (regs_r.state)
            oie_pkg::OIE_IDLE: begin
                if (take_wr || take_rd) begin
                    regs_nxt.state = oie_pkg::OIE_ACK;
                    regs_nxt.ack   = 1'b1;
                end
                if (take_rd) begin
                    if (oie_hit(reg_addr, oie_pkg::OFS_ENABLE_SET) ||
                        oie_hit(reg_addr, oie_pkg::OFS_ENABLE_CLEAR)) begin
                        regs_nxt.rdata = regs_r.enable & oie_pkg::ENABLE_MASK;
                    end else begin
                        regs_nxt.rdata = oie_pkg::READ_UNMAPPED;
                    end
                end
            end
            oie_pkg::OIE_ACK: begin
                // One dead cycle between accesses keeps the answer simple.
                regs_nxt.state = oie_pkg::OIE_IDLE;
            end
            default: begin
                regs_nxt.state = oie_pkg::OIE_IDLE;
            end
        endcase

        // Busy is kept in its own flip-flop so the port needs no decode.
        regs_nxt.busy = regs_nxt.state == oie_pkg::OIE_ACK;

        if (soft_rst) begin
            regs_nxt.rsv_wr = 1'b0;
            regs_nxt.irq    = 1'b0;
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regs_r.state   <= oie_pkg::OIE_IDLE;
            regs_r.enable  <= oie_pkg::ENABLE_RESET;
            regs_r.rdata   <= oie_pkg::READ_UNMAPPED;
            regs_r.pending <= '0;
            regs_r.ack     <= 1'b0;
            regs_r.busy    <= 1'b0;
            regs_r.rsv_wr  <= 1'b0;
            regs_r.irq     <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign reg_rdata         = regs_r.rdata;
    assign reg_ack           = regs_r.ack;
    assign reg_busy          = regs_r.busy;
    assign reserved_write    = regs_r.rsv_wr;
    assign master_irq_enable = regs_r.enable[oie_pkg::BIT_MASTER];
    assign pending_events    = regs_r.pending;
    assign irq_req           = regs_r.irq;

endmodule : oie_top

`default_nettype wire

// ### verif/oie_chk_props.sv
// Checker for the interrupt enable pair, watching the ports of oie_top.
// Assumes a single ref_clk domain and synchronous active-high srst.
`default_nettype none
module oie_chk (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        soft_rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] event_flags,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        reg_busy,
    input wire logic        reserved_write,
    input wire logic        master_irq_enable,
    input wire logic [31:0] pending_events,
    input wire logic        irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Helpers and properties.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // A soft reset beats a coincident write, so writes count only without it.
    wire tk    = (reg_wr || reg_rd) && !reg_busy;
    wire wr_ok = reg_wr && !reg_busy && !soft_rst;
    wire set_w = wr_ok && reg_addr == 8'h10;
    wire clr_w = wr_ok && reg_addr == 8'h14;

    chk_ack_follows: assert property (tk |=> reg_ack && reg_busy)
        else $error("ack or busy missing after access");
    chk_ack_single: assert property (reg_ack |=> !reg_ack && !reg_busy)
        else $error("ack longer than one cycle");
    chk_clear_one: assert property (clr_w && reg_wdata[31] |=> !master_irq_enable)
        else $error("master enable not cleared");
    chk_clear_zero: assert property (clr_w && !reg_wdata[31] && master_irq_enable
        |=> master_irq_enable)
        else $error("master enable lost on zero write");
    chk_set_one: assert property (set_w && reg_wdata[31] |=> master_irq_enable)
        else $error("master enable not set");
    chk_irq_drop: assert property (clr_w && reg_wdata[31] |=> !irq_req)
        else $error("request stays after master clear");
    chk_irq_master: assert property (irq_req |-> master_irq_enable)
        else $error("request without master enable");
    chk_soft_clear: assert property (soft_rst |=> !irq_req && !master_irq_enable
        && !reserved_write)
        else $error("soft reset left state set");
    chk_rsvd_read: assert property (reg_rdata[29:7] == 23'h0 && !pending_events[31])
        else $error("reserved bits read as one");
    chk_rsvd_flag: assert property (wr_ok && |reg_wdata[29:7] |=> reserved_write)
        else $error("reserved write not flagged");

    cov_irq: cover property (irq_req);
    cov_master_clr: cover property (clr_w && reg_wdata[31]);
    cov_rsvd: cover property (reserved_write);
endmodule : oie_chk

bind oie_top oie_chk u_chk (.ref_clk, .srst, .soft_rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .event_flags, .reg_rdata, .reg_ack, .reg_busy, .reserved_write,
    .master_irq_enable, .pending_events, .irq_req);
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for oie_top, driving its register port directly.
// Assumes one access at a time, each followed by the busy cycle.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, srst = 1'b1, soft_rst = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, event_flags = 32'h0;
    logic [31:0] reg_rdata, pending_events;
    logic        reg_ack, reg_busy, reserved_write, master_irq_enable, irq_req;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    int          bl[8] = '{0, 1, 2, 3, 4, 5, 6, 30};

    oie_top dut (.ref_clk, .srst, .soft_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .event_flags, .reg_rdata, .reg_ack, .reg_busy, .reserved_write,
        .master_irq_enable, .pending_events, .irq_req);

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // ****************************************************************
    // Tasks.
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // The request stands until the edge at which ack is seen high; the block
    // is busy there and ignores it, so holding it that long is harmless.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        #1 chk({30'h0, reg_ack, reg_busy}, 32'h3);
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(reg_rdata, e);
    endtask : rd
    task automatic irq(input logic e);
        repeat (2) @(posedge ref_clk);
        #1 chk({31'h0, irq_req}, {31'h0, e});
    endtask : irq
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    // ****************************************************************
    // Timeout and main sequence.
    // ****************************************************************
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            results;
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        acc(1'b1, 8'h10, 32'hc000_007f);
        rd(8'h10, 32'hc000_007f);
        rd(8'h14, 32'hc000_007f);
        foreach (bl[i]) begin
            event_flags <= 32'h1 << bl[i];
            irq(1'b1);
            acc(1'b1, 8'h14, 32'h1 << bl[i]);
            event_flags <= 32'h0;
            #1 chk({31'h0, irq_req}, 32'h0);
            @(posedge ref_clk);
        end
        rd(8'h14, 32'h8000_0000);
        acc(1'b1, 8'h10, 32'h0000_0001);
        event_flags <= 32'h0000_0001;
        irq(1'b1);
        acc(1'b1, 8'h14, 32'h8000_0000);
        irq(1'b0);
        chk(pending_events, 32'h0000_0001);
        acc(1'b1, 8'h10, 32'hffff_ffff);
        rd(8'h14, 32'hc000_007f);
        chk({31'h0, reserved_write}, 32'h1);
        irq(1'b1);
        rd(8'h18, 32'h0);
        @(posedge ref_clk);
        soft_rst <= 1'b1;
        @(posedge ref_clk);
        soft_rst <= 1'b0;
        irq(1'b0);
        rd(8'h10, 32'h0);
        chk({31'h0, reserved_write}, 32'h0);
        // Read and write together: the write wins and the read is dropped.
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b1;
        reg_addr <= 8'h10;
        reg_wdata <= 32'h0000_0004;
        repeat (2) @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        chk(reg_rdata, 32'h0);
        rd(8'h10, 32'h0000_0004);
        results;
    end
endmodule : tb
`default_nettype wire
